// file: rtl/babl_pkg.sv
package babl_pkg;
    // command codes seen with cmd_param_select low
    localparam logic [7:0] CMD_SCANLINE   = 8'hc6;
    localparam logic [7:0] CMD_PWM_POLARITY_SEL    = 8'hc8;
    localparam logic [7:0] CMD_WHITE_RAT  = 8'hc9;
    localparam logic [7:0] CMD_NONE       = 8'h00;
    // reset values of the parameter bytes
    localparam logic [7:0] SCANLINE_RST   = 8'h00;
    localparam logic [7:0] PWM_POLARITY_SEL_RST    = 8'hb0;
    localparam logic [7:0] WHITE_RAT_RST  = 8'hbb;
    // polarity byte layout: bits 7..1 fixed, bit 0 polarity
    localparam int         POL_BIT        = 0;
    localparam logic [6:0] POL_FIXED      = 7'h58;
    // ratio byte layout: moving in high nibble, still in low nibble
    localparam int         MOV_MSB        = 7;
    localparam int         MOV_LSB        = 4;
    localparam int         STILL_MSB      = 3;
    localparam int         STILL_LSB      = 0;
    // ratio code to percent mapping
    localparam logic [6:0] PCT_CODE0      = 7'h63;  // 99
    localparam logic [6:0] PCT_FULL       = 7'h64;  // 100
    localparam logic [6:0] PCT_STEP       = 7'h02;
    // gray levels
    localparam int         GRAY_W         = 6;
    localparam logic [5:0] GRAY_WHITE     = 6'h3f;
    localparam logic [5:0] GRAY_ZERO      = 6'h00;
    localparam int         GRAY_BINS      = 64;

    typedef enum logic [1:0] {
        ST_ACC  = 2'b01,
        ST_SCAN = 2'b10
    } babl_state_t;
endpackage

// file: rtl/babl_ratio_lim.sv
`timescale 1ns/100ps
module babl_ratio_lim
    import babl_pkg::*;
#(
    parameter int CNT_W = 18
) (
    input  wire logic [3:0]       ratio_code,   // 4-bit white ratio code
    input  wire logic [CNT_W-1:0] pix_total,    // pixels in the frame
    output logic      [CNT_W+6:0] white_limit   // total times percent
);
    logic [6:0] pct;

    // code 0 is 99 percent, others 100 minus two per step
    always_comb begin
        if (ratio_code == 4'h0) begin
            pct = PCT_CODE0;
        end else begin
            pct = PCT_FULL - PCT_STEP * {3'h0, ratio_code};
        end
        white_limit = pix_total * pct;
    end
endmodule

// file: rtl/babl_ctrl.sv
`timescale 1ns/100ps
module babl_ctrl
    import babl_pkg::*;
#(
    parameter int CNT_W = 18
) (
    input  wire logic              core_clk,             // 250 MHz clock
    input  wire logic              rst_n,                // sync reset, active low
    input  wire logic              cmd_param_select,     // pin: 0 command, 1 parameter
    input  wire logic              write_strobe_n,       // pin: write strobe, rising edge
    input  wire logic [7:0]        bus_data,             // pin: data byte
    input  wire logic              backlight_on,         // backlight enable
    input  wire logic              pwm_raw,              // raw backlight pwm waveform
    input  wire logic              still_mode,           // 1 still image, 0 moving
    input  wire logic              pixel_valid,          // pixel strobe
    input  wire logic [GRAY_W-1:0] pixel_gray,           // pixel gray level
    input  wire logic              frame_end,            // last pixel of frame seen
    output logic                   backlight_pwm_out,    // pwm pin
    output logic [7:0]             scanline_field,       // stored scan-line byte
    output logic                   pwm_polarity_sel,     // stored polarity bit
    output logic [3:0]             moving_white_ratio,   // stored moving ratio
    output logic [3:0]             still_white_ratio,    // stored still ratio
    output logic [GRAY_W-1:0]      white_gray_threshold, // chosen threshold
    output logic [GRAY_W-1:0]      pixel_out,            // pixel after white mapping
    output logic                   threshold_update      // pulse: new threshold
);
    logic [1:0]          sel_sync;
    logic [2:0]          wr_sync;
    logic [7:0]          data_s1;
    logic [7:0]          data_s2;
    logic                wr_rise;
    logic                cmd_wr;
    logic                param_wr;
    logic [7:0]          cur_cmd;
    logic                param_done;
    logic [7:0]          pol_byte;
    babl_state_t         state;
    logic [CNT_W-1:0]    hist [GRAY_BINS];
    logic [CNT_W-1:0]    pix_total;
    logic [CNT_W-1:0]    scan_total;
    logic [GRAY_W-1:0]   scan_idx;
    logic [CNT_W-1:0]    scan_cum;
    logic [CNT_W-1:0]    next_cum;
    logic [CNT_W+6:0]    white_limit;
    logic                scan_stop;
    logic [3:0]          sel_ratio;
    logic                sel_still;

    // two-flop synchronisers for the bus pins, third stage for edge
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            wr_sync  <= 3'h7;
            sel_sync <= 2'h0;
            data_s1  <= 8'h00;
            data_s2  <= 8'h00;
        end else begin
            wr_sync  <= {wr_sync[1:0], write_strobe_n};
            sel_sync <= {sel_sync[0], cmd_param_select};
            data_s1  <= bus_data;
            data_s2  <= data_s1;
        end
    end

    // write happens on the strobe's rising edge
    assign wr_rise  = wr_sync[1] & ~wr_sync[2];
    assign cmd_wr   = wr_rise & ~sel_sync[1];
    assign param_wr = wr_rise & sel_sync[1];

    // first parameter byte after the given command code
    function automatic logic first_param_of(input logic       wr,
                                            input logic       done,
                                            input logic [7:0] cmd,
                                            input logic [7:0] code);
        return wr && !done && (cmd == code);
    endfunction

    // no power-state gating
    // command latch and first-parameter tracking
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            cur_cmd    <= CMD_NONE;
            param_done <= 1'b0;
        end else if (cmd_wr) begin
            cur_cmd    <= data_s2;
            param_done <= 1'b0;
        end else if (param_wr) begin
            param_done <= 1'b1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            scanline_field <= SCANLINE_RST;
        end else if (first_param_of(param_wr, param_done, cur_cmd, CMD_SCANLINE)) begin
            scanline_field <= data_s2;
        end
    end

    // only polarity bit kept, upper bits fixed
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            pol_byte <= PWM_POLARITY_SEL_RST;
        end else if (first_param_of(param_wr, param_done, cur_cmd, CMD_PWM_POLARITY_SEL)) begin
            pol_byte <= {POL_FIXED, data_s2[POL_BIT]};
        end
    end
    assign pwm_polarity_sel = pol_byte[POL_BIT];

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            moving_white_ratio <= WHITE_RAT_RST[MOV_MSB:MOV_LSB];
            still_white_ratio  <= WHITE_RAT_RST[STILL_MSB:STILL_LSB];
        end else if (first_param_of(param_wr, param_done, cur_cmd, CMD_WHITE_RAT)) begin
            moving_white_ratio <= data_s2[MOV_MSB:MOV_LSB];
            still_white_ratio  <= data_s2[STILL_MSB:STILL_LSB];
        end
    end

    // pwm pin by backlight and polarity
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            backlight_pwm_out <= PWM_POLARITY_SEL_RST[POL_BIT];
        end else if (backlight_on) begin
            backlight_pwm_out <= pwm_raw ^ pwm_polarity_sel;
        end else begin
            backlight_pwm_out <= pwm_polarity_sel;
        end
    end

    // frame state: accumulate, then scan the histogram
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            state <= ST_ACC;
        end else begin
            case (state)
                ST_ACC: begin
                    if (frame_end) begin
                        state <= ST_SCAN;
                    end
                end
                ST_SCAN: begin
                    if (scan_stop) begin
                        state <= ST_ACC;
                    end
                end
                default: begin
                    state <= ST_ACC;
                end
            endcase
        end
    end

    // histogram of gray levels, cleared when a scan ends
    always_ff @(posedge core_clk) begin
        if (!rst_n || (state == ST_SCAN && scan_stop)) begin
            for (int i = 0; i < GRAY_BINS; i++) begin
                hist[i] <= '0;
            end
            pix_total <= '0;
        end else if (state == ST_ACC && pixel_valid) begin
            hist[pixel_gray] <= hist[pixel_gray] + 1'b1;
            pix_total        <= pix_total + 1'b1;
        end
    end

    // moving mode takes the high nibble
    // still mode takes the low nibble
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            sel_still  <= 1'b0;
            scan_total <= '0;
        end else if (state == ST_ACC && frame_end) begin
            sel_still  <= still_mode;
            scan_total <= pix_total;
        end
    end
    assign sel_ratio = sel_still ? still_white_ratio : moving_white_ratio;

    babl_ratio_lim #(
        .CNT_W (CNT_W)
    ) u_ratio_lim (
        .ratio_code  (sel_ratio),
        .pix_total   (scan_total),
        .white_limit (white_limit)
    );

    // stop once white count would exceed the limit
    assign next_cum  = scan_cum + hist[scan_idx];
    assign scan_stop = (next_cum * PCT_FULL > white_limit) || (scan_idx == GRAY_ZERO);

    // scan from the top gray level downward
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            scan_idx             <= GRAY_WHITE;
            scan_cum             <= '0;
            white_gray_threshold <= GRAY_WHITE;
            threshold_update     <= 1'b0;
        end else if (state == ST_SCAN) begin
            threshold_update <= scan_stop;
            if (scan_stop) begin
                scan_idx <= GRAY_WHITE;
                scan_cum <= '0;
                if (next_cum * PCT_FULL <= white_limit) begin
                    white_gray_threshold <= GRAY_ZERO;
                end else if (scan_idx == GRAY_WHITE) begin
                    white_gray_threshold <= GRAY_WHITE;
                end else begin
                    white_gray_threshold <= scan_idx + 1'b1;
                end
            end else begin
                scan_idx <= scan_idx - 1'b1;
                scan_cum <= next_cum;
            end
        end else begin
            threshold_update <= 1'b0;
        end
    end

    // pixels at or above threshold go full white
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            pixel_out <= GRAY_ZERO;
        end else if (pixel_valid) begin
            pixel_out <= (pixel_gray >= white_gray_threshold) ? GRAY_WHITE : pixel_gray;
        end
    end

    chk_pwm_off_level: assert property (@(posedge core_clk) disable iff (!rst_n)
        !backlight_on |=> backlight_pwm_out == $past(pwm_polarity_sel))
        else $error("pwm pin not at polarity level while backlight off");

    chk_pwm_on_wave: assert property (@(posedge core_clk) disable iff (!rst_n)
        backlight_on |=> backlight_pwm_out == ($past(pwm_raw) ^ $past(pwm_polarity_sel)))
        else $error("pwm pin not following waveform while backlight on");

    chk_scanline_store: assert property (@(posedge core_clk) disable iff (!rst_n)
        (param_wr && !param_done && cur_cmd == CMD_SCANLINE)
            |=> scanline_field == $past(data_s2))
        else $error("scan-line byte not stored");

    chk_pol_fixed_bits: assert property (@(posedge core_clk) disable iff (!rst_n)
        pol_byte[7:1] == POL_FIXED)
        else $error("polarity byte fixed bits changed");

    chk_pol_store: assert property (@(posedge core_clk) disable iff (!rst_n)
        (param_wr && !param_done && cur_cmd == CMD_PWM_POLARITY_SEL)
            |=> pwm_polarity_sel == $past(data_s2[POL_BIT]))
        else $error("polarity bit not stored");

    chk_ratio_store: assert property (@(posedge core_clk) disable iff (!rst_n)
        (param_wr && !param_done && cur_cmd == CMD_WHITE_RAT)
            |=> {moving_white_ratio, still_white_ratio} == $past(data_s2))
        else $error("ratio byte not stored");

    chk_ratio_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
        !(param_wr && cur_cmd == CMD_WHITE_RAT) |=> $stable(moving_white_ratio))
        else $error("moving ratio changed without a write");

    chk_reset_defaults: assert property (@(posedge core_clk)
        !rst_n |=> pol_byte == PWM_POLARITY_SEL_RST
            && moving_white_ratio == WHITE_RAT_RST[MOV_MSB:MOV_LSB]
            && still_white_ratio == WHITE_RAT_RST[STILL_MSB:STILL_LSB]
            && scanline_field == SCANLINE_RST)
        else $error("defaults not loaded at reset");

    chk_ratio_select: assert property (@(posedge core_clk) disable iff (!rst_n)
        (state == ST_ACC && frame_end && !still_mode)
            |=> sel_ratio == moving_white_ratio)
        else $error("moving frame did not use moving ratio");

    chk_still_select: assert property (@(posedge core_clk) disable iff (!rst_n)
        (state == ST_ACC && frame_end && still_mode)
            |=> sel_ratio == still_white_ratio)
        else $error("still frame did not use still ratio");

    chk_scan_bound: assert property (@(posedge core_clk) disable iff (!rst_n)
        (state == ST_ACC && frame_end) |-> ##[1:65] threshold_update)
        else $error("threshold not chosen within the scan bound");
endmodule

// file: sim/babl_host_model.sv
`timescale 1ns/100ps
module babl_host_model (
    output logic       cmd_param_select, // 0 command, 1 parameter
    output logic       write_strobe_n,   // write strobe pin
    output logic [7:0] bus_data,         // data pins
    input  wire logic  core_clk          // device clock
);
    // idle: strobe high, bus not driven by anything meaningful
    initial begin
        cmd_param_select = 1'b1;
        write_strobe_n   = 1'b1;
        bus_data         = 8'h5a;
    end

    // one byte: strobe low for lo cycles, rise, hold, then let the bus drift
    task automatic put(input logic sel, input logic [7:0] d, input int lo);
        @(posedge core_clk) #1;
        cmd_param_select = sel;
        bus_data         = d;
        write_strobe_n   = 1'b0;
        repeat (lo) @(posedge core_clk);
        #1 write_strobe_n = 1'b1;
        repeat (3) @(posedge core_clk);
        #1 bus_data = ~d;
        repeat (2) @(posedge core_clk);
        #1;
    endtask

    task automatic write_reg(input logic [7:0] cmd, input logic [7:0] prm, input int lo);
        put(1'b0, cmd, lo);
        put(1'b1, prm, lo);
    endtask
endmodule

// file: sim/babl_ctrl_tb.sv
`timescale 1ns/100ps
module babl_ctrl_tb
    import babl_pkg::*;
;
    logic              core_clk;
    logic              rst_n;
    logic              cmd_param_select;
    logic              write_strobe_n;
    logic [7:0]        bus_data;
    logic              backlight_on;
    logic              pwm_raw;
    logic              still_mode;
    logic              pixel_valid;
    logic [GRAY_W-1:0] pixel_gray;
    logic              frame_end;
    logic              backlight_pwm_out;
    logic [7:0]        scanline_field;
    logic              pwm_polarity_sel;
    logic [3:0]        moving_white_ratio;
    logic [3:0]        still_white_ratio;
    logic [GRAY_W-1:0] white_gray_threshold;
    logic [GRAY_W-1:0] pixel_out;
    logic              threshold_update;
    logic [GRAY_W-1:0] last_thr;
    int                failures;
    int                cmp_count;
    int                cycles;

    babl_ctrl DUT (
        .core_clk, .rst_n, .cmd_param_select, .write_strobe_n, .bus_data,
        .backlight_on, .pwm_raw, .still_mode, .pixel_valid, .pixel_gray,
        .frame_end, .backlight_pwm_out, .scanline_field, .pwm_polarity_sel,
        .moving_white_ratio, .still_white_ratio, .white_gray_threshold,
        .pixel_out, .threshold_update
    );

    babl_host_model H (.cmd_param_select, .write_strobe_n, .bus_data, .core_clk);

    always #2 core_clk = ~core_clk;

    // hang guard
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            failures++;
            final_report();
        end
    end

    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic final_report;
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // reset pulse, then every stored value back at its default
    task automatic t_reset;
        last_thr = GRAY_WHITE;
        rst_n = 1'b0;
        repeat (8) @(posedge core_clk);
        #1 rst_n = 1'b1;
        @(posedge core_clk) #1;
        check("scanline", scanline_field, SCANLINE_RST);
        check("polarity", 8'(pwm_polarity_sel), 8'(PWM_POLARITY_SEL_RST[POL_BIT]));
        check("ratios", {moving_white_ratio, still_white_ratio}, WHITE_RAT_RST);
        check("threshold", 8'(white_gray_threshold), 8'h3f);
        check("pwm_out", 8'(backlight_pwm_out), 8'h00);
    endtask

    // stores, polarity table on the pin, nibble split, ignored bytes
    task automatic t_regs;
        H.write_reg(CMD_SCANLINE, 8'ha5, 8);
        check("scanline", scanline_field, 8'ha5);
        for (int p = 0; p < 2; p++) begin
            H.write_reg(CMD_PWM_POLARITY_SEL, p ? 8'h4f : 8'hb0, 2);
            check("polarity", 8'(pwm_polarity_sel), 8'(p));
            for (int k = 0; k < 4; k++) begin
                backlight_on = k[1];
                pwm_raw = k[0];
                repeat (2) @(posedge core_clk);
                #1;
                check("pwm_out", 8'(backlight_pwm_out), 8'(k[1] ? k[0] ^ p[0] : p[0]));
            end
        end
        backlight_on = 1'b0;
        H.write_reg(CMD_WHITE_RAT, 8'h5a, 8);
        H.put(1'b1, 8'h33, 2);
        H.write_reg(8'hc7, 8'h77, 2);
        check("moving", 8'(moving_white_ratio), 8'h05);
        check("still", 8'(still_white_ratio), 8'h0a);
        check("scanline_hold", scanline_field, 8'ha5);
    endtask

    // 100 pixels, gray = i mod 64, then frame end and threshold scan
    task automatic t_frame(input logic still, input logic [5:0] exp_thr);
        logic [5:0] thr;
        int         n;
        thr = last_thr;
        pixel_valid = 1'b1;
        for (int i = 0; i < 100; i++) begin
            pixel_gray = 6'(i % 64);
            @(posedge core_clk) #1;
            check("pixel_out", 8'(pixel_out), (pixel_gray >= thr) ? 8'h3f : 8'(pixel_gray));
        end
        pixel_valid = 1'b0;
        still_mode = still;
        frame_end = 1'b1;
        @(posedge core_clk) #1;
        frame_end = 1'b0;
        n = 0;
        while (threshold_update !== 1'b1 && n < 70) begin
            @(posedge core_clk) #1;
            n++;
        end
        check("update", 8'(threshold_update), 8'h01);
        check("threshold", 8'(white_gray_threshold), 8'(exp_thr));
        last_thr = exp_thr;
    endtask

    // count(gray >= t) = 100 - 2t below 36, so code c gives t = c, code 0 gives 1
    task automatic t_ratios;
        for (int c = 0; c < 16; c++) begin
            H.write_reg(CMD_WHITE_RAT, {4'(c), 4'(15 - c)}, 2);
            t_frame(1'b0, (c == 0) ? 6'h01 : 6'(c));
            t_frame(1'b1, (c == 15) ? 6'h01 : 6'(15 - c));
        end
    endtask

    initial begin
        core_clk = 1'b0;
        rst_n = 1'b0;
        backlight_on = 1'b0;
        pwm_raw = 1'b0;
        still_mode = 1'b0;
        pixel_valid = 1'b0;
        pixel_gray = '0;
        frame_end = 1'b0;
        failures = 0;
        cmp_count = 0;
        cycles = 0;
        t_reset();
        t_regs();
        t_ratios();
        t_reset();
        final_report();
    end
endmodule
